// ==== hdl/eal_map.svh ====
`ifndef EAL_MAP_SVH
`define EAL_MAP_SVH
// What this block does
// - Start bit 0 to 1 begins one cycle; direction 0 read, 1 write.
// - Start bit clears itself when the cycle has finished.
// - Bit 2 flags a missing acknowledge; stays 0 otherwise.
// - Bit 3 reads 1 after a successful autoload, else 0.
// - Serial clock is core clock over 4096, 2048, 1024 or 128.
// - Autoload starts after reset only if bit 6 is 0; reset value 0.
// - Fast bit makes autoload 32 times faster; reset value 1.
// - Bit 8 reads 1 while autoload is in progress.
// - Bits 15:9 give the word address of a software cycle.
// - A write cycle sends bits 31:16 to the selected word.

// Register offset and field positions
`define EAL_CTRL_OFS 8'h70
`define EAL_B_START 0
`define EAL_B_DIR 1
`define EAL_B_ERR 2
`define EAL_B_DONE 3
`define EAL_DIV_LO 4
`define EAL_DIV_HI 5
`define EAL_B_ALDIS 6
`define EAL_B_FAST 7
`define EAL_B_ALBUSY 8
`define EAL_ADDR_LO 9
`define EAL_ADDR_HI 15
`define EAL_DATA_LO 16
`define EAL_DATA_HI 31

// Reset values
`define EAL_DIV_RST 2'h0
`define EAL_FAST_RST 1'b1
`define EAL_ADDR_RST 7'h00
`define EAL_DATA_RST 16'h0000

// Clock rates and divider ratios
`define EAL_CORE_MHZ 125
`define EAL_SYS_MHZ 250
`define EAL_DIV_0 4096
`define EAL_DIV_1 2048
`define EAL_DIV_2 1024
`define EAL_DIV_3 128
`define EAL_FAST_SHIFT 5
`define EAL_PHASES 4

// Serial framing
`define EAL_DEV_WR 8'ha0
`define EAL_DEV_RD 8'ha1
`define EAL_BITS 4'h9
`define EAL_AUTO_WORDS 16
`endif

// ==== hdl/eal_pkg.sv ====
package eal_pkg;
    // Byte-level serial operations
    typedef enum logic [1:0] {op_start, op_stop, op_wr, op_rd} eal_op_t;
endpackage : eal_pkg

// ==== hdl/eal_ser_if.sv ====
`timescale 1ns/1ps
interface eal_ser_if;
    logic ce;
    logic go;
    eal_pkg::eal_op_t op;
    logic [7:0] wbyte;
    logic last;
    logic fast;
    logic [1:0] div;
    logic done;
    logic [7:0] rbyte;
    logic nack;
    modport seq (output ce, go, op, wbyte, last, fast, div, input done, rbyte, nack);
    modport eng (input ce, go, op, wbyte, last, fast, div, output done, rbyte, nack);
endinterface : eal_ser_if

// ==== hdl/eal_serial.sv ====
`timescale 1ns/1ps
`include "eal_map.svh"
module eal_serial #(
    parameter int DIV0 = `EAL_DIV_0,
    parameter int DIV1 = `EAL_DIV_1,
    parameter int DIV2 = `EAL_DIV_2,
    parameter int DIV3 = `EAL_DIV_3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Sequencer side
    eal_ser_if.eng ser,
    // Serial pins
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out
);
    import eal_pkg::*;
    localparam int QW = 16;

    logic busy_reg;
    eal_op_t op_reg;
    logic [QW-1:0] cnt_reg;
    logic [QW-1:0] lim_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic [8:0] sh_reg;
    logic [8:0] rx_reg;
    logic done_reg;
    logic sda_low;
    logic scl_high;
    logic tick;
    logic bit_end;
    logic op_end;

    // Quarter-bit length in system clocks, less one (counter reload value)
    function automatic logic [QW-1:0] quarter(input logic [1:0] sel, input logic fast);
        int n;
        case (sel)
            2'h0: n = DIV0;
            2'h1: n = DIV1;
            2'h2: n = DIV2;
            default: n = DIV3;
        endcase
        n = n * `EAL_SYS_MHZ / `EAL_CORE_MHZ / `EAL_PHASES;
        if (fast) begin
            n = n >> `EAL_FAST_SHIFT;
        end
        if (n < 1) begin
            n = 1;
        end
        quarter = QW'(n - 1);
    endfunction : quarter

    assign tick = busy_reg && (cnt_reg == '0);
    assign bit_end = tick && (ph_reg == 2'h3);
    assign op_end = bit_end && ((op_reg == op_start) || (op_reg == op_stop)
                                || (bit_reg == `EAL_BITS - 4'h1));

    // Operation, phase and bit counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            op_reg <= op_start;
            cnt_reg <= '0;
            lim_reg <= '0;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            sh_reg <= 9'h1ff;
        end else if (ser.ce) begin
            if (!busy_reg && ser.go) begin
                busy_reg <= 1'b1;
                op_reg <= ser.op;
                lim_reg <= quarter(ser.div, ser.fast);
                cnt_reg <= quarter(ser.div, ser.fast);
                ph_reg <= 2'h0;
                bit_reg <= 4'h0;
                sh_reg <= (ser.op == op_rd) ? {8'hff, ser.last} : {ser.wbyte, 1'b1};
            end else if (tick) begin
                cnt_reg <= lim_reg;
                ph_reg <= ph_reg + 2'h1;
                if (op_end) begin
                    busy_reg <= 1'b0;
                end else if (bit_end) begin
                    bit_reg <= bit_reg + 4'h1;
                    sh_reg <= {sh_reg[7:0], 1'b1};
                end
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - QW'(1);
            end
        end
    end

    // Received bits and completion pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_reg <= 9'h000;
            done_reg <= 1'b0;
        end else if (ser.ce) begin
            done_reg <= op_end;
            if (tick && ph_reg == 2'h1 && (op_reg == op_wr || op_reg == op_rd)) begin
                rx_reg <= {rx_reg[7:0], sda_in};
            end
        end
    end

    // Wanted pin levels by operation and phase
    always_comb begin
        sda_low = !sda_oe_n;
        scl_high = scl_out;
        if (busy_reg) begin
            case (op_reg)
                op_start: begin
                    sda_low = ph_reg[1];
                    scl_high = (ph_reg != 2'h3);
                end
                op_stop: begin
                    sda_low = (ph_reg != 2'h3);
                    scl_high = (ph_reg != 2'h0);
                end
                default: begin
                    sda_low = !sh_reg[8];
                    scl_high = (ph_reg == 2'h1) || (ph_reg == 2'h2);
                end
            endcase
        end
    end

    // Pin flops; bus idles released and high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_oe_n <= 1'b1;
            scl_out <= 1'b1;
        end else if (ser.ce) begin
            sda_oe_n <= !sda_low;
            scl_out <= scl_high;
        end
    end

    assign sda_out = 1'b0;
    assign ser.done = done_reg;
    assign ser.rbyte = rx_reg[8:1];
    assign ser.nack = rx_reg[0];
endmodule : eal_serial

// ==== hdl/eal_top.sv ====
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "eal_map.svh"
module eal_top #(
    parameter int DIV0 = `EAL_DIV_0,
    parameter int DIV1 = `EAL_DIV_1,
    parameter int DIV2 = `EAL_DIV_2,
    parameter int DIV3 = `EAL_DIV_3,
    parameter int AUTO_WORDS = `EAL_AUTO_WORDS
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // EEPROM serial pins
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    // Autoloaded configuration words
    output logic cfg_wr,
    output logic [6:0] cfg_addr,
    output logic [15:0] cfg_data
);
    import eal_pkg::*;

    typedef enum logic [3:0] {
        st_boot,
        st_idle,
        st_start,
        st_devw,
        st_waddr,
        st_wdhi,
        st_wdlo,
        st_rstart,
        st_devr,
        st_rdhi,
        st_rdlo,
        st_stop,
        st_done
    } eal_state_t;

    // Control and status fields
    logic start_reg;
    logic dir_reg;
    logic err_reg;
    logic done_reg;
    logic [1:0] div_reg;
    logic aldis_reg;
    logic fast_reg;
    logic [6:0] addr_reg;
    logic [15:0] data_reg;

    // Sequencer state
    eal_state_t st_reg;
    logic wait_reg;
    logic al_reg;
    logic fail_reg;
    logic [6:0] word_reg;
    logic [15:0] rdat_reg;

    // Bus decode
    logic acc;
    logic wr_en;
    logic [31:0] rd_word;

    // Sequencer command
    logic issuing;
    logic is_wr_op;
    logic step;
    logic bad_ack;
    logic last_word;

    eal_ser_if ser ();

    // Register offset decode
    function automatic logic is_ctrl(input logic [7:0] a);
        is_ctrl = (a == `EAL_CTRL_OFS);
    endfunction : is_ctrl

    // APB handshake, always zero wait
    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = acc && !is_ctrl(paddr);
    assign wr_en = acc && pwrite && is_ctrl(paddr);

    // Read view of the control word
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[`EAL_B_START] = start_reg;
        rd_word[`EAL_B_DIR] = dir_reg;
        rd_word[`EAL_B_ERR] = err_reg;
        rd_word[`EAL_B_DONE] = done_reg;
        rd_word[`EAL_DIV_HI:`EAL_DIV_LO] = div_reg;
        rd_word[`EAL_B_ALDIS] = aldis_reg;
        rd_word[`EAL_B_FAST] = fast_reg;
        rd_word[`EAL_B_ALBUSY] = al_reg;
        rd_word[`EAL_ADDR_HI:`EAL_ADDR_LO] = addr_reg;
        rd_word[`EAL_DATA_HI:`EAL_DATA_LO] = data_reg;
    end

    // Read data captured in the setup phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (psel && !penable && !pwrite) begin
                prdata <= is_ctrl(paddr) ? rd_word : 32'h0000_0000;
            end
        end
    end

    // Settings that may change at any time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_reg <= `EAL_DIV_RST;
            aldis_reg <= 1'b0;
            fast_reg <= `EAL_FAST_RST;
        end else if (ce) begin
            if (wr_en) begin
                div_reg <= pwdata[`EAL_DIV_HI:`EAL_DIV_LO];
                aldis_reg <= pwdata[`EAL_B_ALDIS];
                fast_reg <= pwdata[`EAL_B_FAST];
            end
        end
    end

    // Cycle fields, frozen while a cycle is pending
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dir_reg <= 1'b0;
            addr_reg <= `EAL_ADDR_RST;
        end else if (ce) begin
            if (wr_en && !start_reg) begin
                dir_reg <= pwdata[`EAL_B_DIR];
                addr_reg <= pwdata[`EAL_ADDR_HI:`EAL_ADDR_LO];
            end
        end
    end

    // Start bit: set by software edge, cleared at finish
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else if (ce) begin
            if (start_reg) begin
                if (st_reg == st_done && !al_reg) begin
                    start_reg <= 1'b0;
                end
            end else if (wr_en && pwdata[`EAL_B_START]) begin
                start_reg <= 1'b1;
            end
        end
    end

    // Data field: software value or returned word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_reg <= `EAL_DATA_RST;
        end else if (ce) begin
            if (st_reg == st_done && !al_reg && start_reg) begin
                if (!dir_reg && !fail_reg) begin
                    data_reg <= rdat_reg;
                end
            end else if (wr_en && !start_reg) begin
                data_reg <= pwdata[`EAL_DATA_HI:`EAL_DATA_LO];
            end
        end
    end

    // Command issued in each serial state
    always_comb begin
        issuing = 1'b1;
        is_wr_op = 1'b1;
        ser.op = op_wr;
        ser.wbyte = 8'hff;
        ser.last = 1'b0;
        case (st_reg)
            st_start, st_rstart: begin
                ser.op = op_start;
                is_wr_op = 1'b0;
            end
            st_devw: ser.wbyte = `EAL_DEV_WR;
            st_waddr: ser.wbyte = {1'b0, word_reg};
            st_wdhi: ser.wbyte = data_reg[15:8];
            st_wdlo: ser.wbyte = data_reg[7:0];
            st_devr: ser.wbyte = `EAL_DEV_RD;
            st_rdhi: begin
                ser.op = op_rd;
                is_wr_op = 1'b0;
            end
            st_rdlo: begin
                ser.op = op_rd;
                ser.last = 1'b1;
                is_wr_op = 1'b0;
            end
            st_stop: begin
                ser.op = op_stop;
                is_wr_op = 1'b0;
            end
            default: begin
                issuing = 1'b0;
                is_wr_op = 1'b0;
            end
        endcase
    end

    // Engine hookup
    assign ser.ce = ce;
    assign ser.go = issuing && !wait_reg;
    assign ser.div = div_reg;
    assign ser.fast = fast_reg && al_reg;
    assign step = wait_reg && ser.done;
    assign bad_ack = step && is_wr_op && ser.nack;
    assign last_word = (word_reg == 7'(AUTO_WORDS - 1));

    // Issue and wait handshake
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_reg <= 1'b0;
        end else if (ce) begin
            if (ser.go) begin
                wait_reg <= 1'b1;
            end else if (ser.done) begin
                wait_reg <= 1'b0;
            end
        end
    end

    // Transaction sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= st_boot;
            al_reg <= 1'b0;
            fail_reg <= 1'b0;
            word_reg <= 7'h00;
            rdat_reg <= 16'h0000;
        end else if (ce) begin
            case (st_reg)
                st_boot: begin
                    if (!aldis_reg) begin
                        al_reg <= 1'b1;
                        fail_reg <= 1'b0;
                        word_reg <= 7'h00;
                        st_reg <= st_start;
                    end else begin
                        st_reg <= st_idle;
                    end
                end
                st_idle: begin
                    if (start_reg) begin
                        word_reg <= addr_reg;
                        fail_reg <= 1'b0;
                        st_reg <= st_start;
                    end
                end
                st_done: begin
                    if (al_reg && !fail_reg && !last_word) begin
                        word_reg <= word_reg + 7'h01;
                        st_reg <= st_start;
                    end else begin
                        al_reg <= 1'b0;
                        st_reg <= st_idle;
                    end
                end
                default: begin
                    if (bad_ack) begin
                        fail_reg <= 1'b1;
                        st_reg <= st_stop;
                    end else if (step) begin
                        case (st_reg)
                            st_start: st_reg <= st_devw;
                            st_devw: st_reg <= st_waddr;
                            st_waddr: st_reg <= (dir_reg && !al_reg) ? st_wdhi : st_rstart;
                            st_wdhi: st_reg <= st_wdlo;
                            st_wdlo: st_reg <= st_stop;
                            st_rstart: st_reg <= st_devr;
                            st_devr: st_reg <= st_rdhi;
                            st_rdhi: begin
                                rdat_reg[15:8] <= ser.rbyte;
                                st_reg <= st_rdlo;
                            end
                            st_rdlo: begin
                                rdat_reg[7:0] <= ser.rbyte;
                                st_reg <= st_stop;
                            end
                            st_stop: st_reg <= st_done;
                            default: st_reg <= st_idle;
                        endcase
                    end
                end
            endcase
        end
    end

    // Error flag: cleared at cycle start, set on missing acknowledge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            err_reg <= 1'b0;
        end else if (ce) begin
            if (bad_ack) begin
                err_reg <= 1'b1;
            end else if ((st_reg == st_idle && start_reg) || (st_reg == st_boot && !aldis_reg)) begin
                err_reg <= 1'b0;
            end
        end
    end

    // Autoload success flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else if (ce) begin
            if (st_reg == st_done && al_reg && !fail_reg && last_word) begin
                done_reg <= 1'b1;
            end
        end
    end

    // Autoloaded word strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_wr <= 1'b0;
            cfg_addr <= 7'h00;
            cfg_data <= 16'h0000;
        end else if (ce) begin
            cfg_wr <= 1'b0;
            if (st_reg == st_done && al_reg && !fail_reg) begin
                cfg_wr <= 1'b1;
                cfg_addr <= word_reg;
                cfg_data <= rdat_reg;
            end
        end
    end

    // Bit-level serial engine
    eal_serial #(
        .DIV0(DIV0),
        .DIV1(DIV1),
        .DIV2(DIV2),
        .DIV3(DIV3)
    ) u_serial (
        .sys_clk(sys_clk),
        .rst(rst),
        .ser(ser.eng),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .scl_out(scl_out)
    );
endmodule : eal_top

// ==== tb/eal_eeprom_model.sv ====
`timescale 1ns/1ps
module eal_eeprom_model (
    // Clock and serial lines
    input wire logic sys_clk,
    input wire logic scl,
    input wire logic sda,
    // Refuse acknowledges
    input wire logic nack_en,
    // Open drain, 1 releases the line
    output logic sda_rel = 1'b1
);
    logic scl_q = 1'b1, sda_q = 1'b1, rd_mode = 1'b0, lsb = 1'b0;
    logic [3:0] bitn = 4'h0;
    logic [7:0] sh = 8'h00, wbuf = 8'h00;
    logic [6:0] ptr = 7'h00;
    logic [15:0] mem [128];
    int nbyte = 0;
    // Framing, shifting and acknowledges
    always @(posedge sys_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda) begin
            // Start's own scl fall wraps this to bit 0
            bitn <= 4'hf;
            nbyte <= 0;
            rd_mode <= 1'b0;
            lsb <= 1'b0;
            sda_rel <= 1'b1;
        end else if (scl && scl_q && !sda_q && sda) begin
            rd_mode <= 1'b0;
            sda_rel <= 1'b1;
        end else if (scl && !scl_q) begin
            if (bitn < 4'h8 && !rd_mode) sh <= {sh[6:0], sda};
            if (bitn == 4'h8 && rd_mode && sda) begin
                rd_mode <= 1'b0;
                nbyte <= 9;
            end
        end else if (!scl && scl_q) begin
            if (bitn == 4'h7) begin
                bitn <= 4'h8;
                sda_rel <= rd_mode | nack_en;
                if (!rd_mode && !nack_en) begin
                    nbyte <= nbyte + 1;
                    if (nbyte == 1) ptr <= sh[6:0];
                    if (nbyte == 2) wbuf <= sh;
                    if (nbyte == 3) mem[ptr] <= {wbuf, sh};
                end
            end else if (bitn == 4'h8) begin
                bitn <= 4'h0;
                sda_rel <= 1'b1;
                if (rd_mode || (nbyte == 1 && sh[0])) begin
                    sh <= lsb ? mem[ptr][7:0] : mem[ptr][15:8];
                    sda_rel <= lsb ? mem[ptr][7] : mem[ptr][15];
                    if (lsb) ptr <= ptr + 7'h01;
                    lsb <= !lsb;
                    rd_mode <= 1'b1;
                end
            end else begin
                bitn <= bitn + 4'h1;
                if (rd_mode) sda_rel <= sh[3'd6 - bitn[2:0]];
            end
        end
    end
endmodule : eal_eeprom_model

// ==== tb/eal_top_checker.sv ====
`timescale 1ns/1ps
module eal_top_checker #(
    parameter int AUTO_WORDS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    // Serial pins and autoload output
    input wire logic sda_oe_n,
    input wire logic scl_out,
    input wire logic cfg_wr,
    input wire logic [6:0] cfg_addr
);
    logic rd_ctl;
    logic done_seen_reg;
    logic [6:0] last_addr_reg;
    int wcnt_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Control word read in its access phase
    assign rd_ctl = psel && penable && !pwrite && paddr == 8'h70;
    // Completion once seen by software
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_seen_reg <= 1'b0;
        end else if (rd_ctl && prdata[3]) begin
            done_seen_reg <= 1'b1;
        end
    end
    // Autoloaded word count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wcnt_reg <= 0;
        end else if (cfg_wr) begin
            wcnt_reg <= wcnt_reg + 1;
        end
    end
    // Address of the last word
    always_ff @(posedge sys_clk) begin
        if (cfg_wr) begin
            last_addr_reg <= cfg_addr;
        end
    end
    chk_reset_outputs: assert property (
        $fell(rst) |-> prdata == 32'h0 && sda_oe_n && scl_out && !cfg_wr)
        else $error("outputs not at reset values");
    chk_done_sticky: assert property (
        rd_ctl && done_seen_reg |-> prdata[3]) else $error("done bit lost");
    chk_done_not_busy: assert property (
        rd_ctl && prdata[3] |-> !prdata[8]) else $error("busy with done");
    chk_no_late_word: assert property (
        cfg_wr |-> !done_seen_reg) else $error("word after autoload end");
    chk_scl_quarter: assert property (
        $changed(scl_out) |=> $stable(scl_out) [*3]) else $error("serial clock too fast");
    chk_first_word: assert property (
        cfg_wr && wcnt_reg == 0 |-> cfg_addr == 7'h00) else $error("first word not 0");
    chk_word_step: assert property (
        cfg_wr && wcnt_reg != 0 |-> cfg_addr == last_addr_reg + 7'h01)
        else $error("word address skipped");
    chk_word_count: assert property (
        cfg_wr |-> wcnt_reg < AUTO_WORDS) else $error("too many words");
    chk_word_pulse: assert property (
        cfg_wr |=> !cfg_wr) else $error("word strobe too long");
    cover property (cfg_wr);
    cover property (rd_ctl && prdata[3]);
    cover property (rd_ctl && prdata[2]);
endmodule : eal_top_checker

bind eal_top eal_top_checker #(.AUTO_WORDS(AUTO_WORDS)) eal_top_checker_i (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr));

// ==== tb/test_eeprom_autoload_access_control.sv ====
`timescale 1ns/1ps
module test_eeprom_autoload_access_control;
    localparam int AW = 2;
    localparam int LIM = 60000;
    int dv_tab [4] = '{256, 64, 32, 8};
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, nack_en = 1'b0, scl_d = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sda_out, sda_oe_n, scl_out, sda_rel, cfg_wr;
    logic [6:0] cfg_addr;
    logic [15:0] cfg_data;
    logic [15:0] ee_mem [128];
    wire logic sda_w;
    int error_cnt = 0, samples_checked = 0, cyc = 0, nwords = 0;
    // Open-drain line with pull-up
    assign sda_w = (sda_oe_n === 1'b0 ? sda_out : 1'b1) & sda_rel;
    eal_top #(.DIV0(256), .DIV1(64), .DIV2(32), .DIV3(8), .AUTO_WORDS(AW)) eal_top_i (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .scl_out(scl_out), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data));
    eal_eeprom_model eal_eeprom_model_i (.sys_clk(sys_clk), .scl(scl_out), .sda(sda_w),
        .nack_en(nack_en), .sda_rel(sda_rel));
    always #2 sys_clk = ~sys_clk;
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Cycle count, hang guard, edge history
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        scl_d <= scl_out;
        if (cyc == LIM) begin
            error_cnt++;
            finish_test();
        end
    end
    // Autoloaded words against preloaded content
    always @(posedge sys_clk) begin
        if (!rst && cfg_wr === 1'b1) begin
            chk(32'({cfg_addr, cfg_data}), 32'({7'(nwords), ee_mem[nwords]}));
            nwords++;
        end
    end
    function automatic logic [31:0] ctl(input logic [15:0] d, input logic [6:0] a,
        input logic [1:0] dv, input logic er, input logic dir, input logic st);
        return {d, a, 3'b001, dv, 1'b1, er, dir, st};
    endfunction : ctl
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wait_idle(output logic [31:0] q);
        logic e;
        do begin
            apb(1'b0, 8'h70, 32'h0, q, e);
        end while ((q[0] | q[8]) !== 1'b0);
    endtask : wait_idle
    task automatic sw(input logic dir, input logic [1:0] dv, input logic [6:0] a,
        input logic [15:0] d, input logic er);
        logic [31:0] q;
        logic e;
        int p, n, t0;
        n = 0;
        t0 = 0;
        apb(1'b1, 8'h70, ctl(d, a, dv, 1'b0, dir, 1'b1), q, e);
        while (n < 2) begin
            @(posedge sys_clk);
            if (scl_out === 1'b1 && scl_d === 1'b0) begin
                p = cyc - t0;
                t0 = cyc;
                n++;
            end
        end
        wait_idle(q);
        if (!dir) d = ee_mem[a];
        if (dir && !er) ee_mem[a] = d;
        chk(32'(p), 32'(2 * dv_tab[dv]));
        chk(q, ctl(d, a, dv, er, dir, 1'b0));
        chk(32'(eal_eeprom_model_i.mem[a]), 32'(ee_mem[a]));
    endtask : sw
    initial begin
        logic [31:0] q;
        logic e;
        int t;
        logic [6:0] a;
        void'($urandom(32'hf047));
        for (int i = 0; i < 128; i++) begin
            ee_mem[i] = 16'($urandom);
            eal_eeprom_model_i.mem[i] = ee_mem[i];
        end
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, 8'h70, 32'h0, q, e);
        chk(q, 32'h0000_0180);
        wait_idle(q);
        t = cyc;
        chk(q, 32'h0000_0088);
        chk(32'(nwords), 32'(AW));
        chk(32'(t > AW * 640 && t < AW * 960), 32'h1);
        apb(1'b1, 8'h70, 32'h0000_017c, q, e);
        apb(1'b0, 8'h70, 32'h0, q, e);
        chk(q, 32'h0000_0078);
        for (int i = 0; i < 4; i++) begin
            a = 7'($urandom);
            sw(1'b1, 2'(3 - i), a, 16'($urandom), 1'b0);
        end
        sw(1'b0, 2'h3, a, 16'($urandom), 1'b0);
        sw(1'b0, 2'h3, 7'($urandom), 16'hffff, 1'b0);
        nack_en <= 1'b1;
        sw(1'b1, 2'h3, a, 16'h5a5a, 1'b1);
        nack_en <= 1'b0;
        sw(1'b0, 2'h3, a, 16'h0000, 1'b0);
        // Enable low: a start write must leave the register untouched
        ce <= 1'b0;
        apb(1'b1, 8'h70, 32'h0000_0001, q, e);
        ce <= 1'b1;
        apb(1'b0, 8'h70, 32'h0, q, e);
        chk(q, ctl(ee_mem[a], a, 2'h3, 1'b0, 1'b0, 1'b0));
        apb(1'b0, 8'h70 ^ 8'($urandom_range(255, 1)), 32'h0, q, e);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        chk(32'(nwords), 32'(AW));
        finish_test();
    end
endmodule : test_eeprom_autoload_access_control
